// ### hdl/iepb_bank.v
// interrupt flag, enable and priority register bank with request selection
// ==========================================================================
// Operation
// [RULE1] uart A error flag reads pending state
// [RULE2] enable bit one allows, zero blocks
// [RULE3] enable register zero bit layout
// [RULE4] enable register one bit layout
// [RULE5] enable register two bit layout
// [RULE6] uart A error enable at bit 1
// [RULE7] priority 1..7, zero disables source
// [RULE8] priority register zero field layout
// [RULE9] unimplemented bits read zero, ignore writes
// [RULE10] request only when flagged, enabled, prioritised
module iepb_bank (
    input  wire        ref_clk_i,          // system clock, 25 MHz
    input  wire        rst_i,              // synchronous reset, active high
    input  wire [3:0]  addr_i,             // register word address
    input  wire [15:0] wdata_i,            // write data
    input  wire        wr_i,               // write strobe
    input  wire        rd_i,               // read strobe
    output reg  [15:0] rdata_o,            // read data, valid cycle after rd_i
    input  wire        uart_a_err_evt_i,   // uart A error event pulse
    input  wire        uart_b_err_evt_i,   // uart B error event pulse
    input  wire        crc_evt_i,          // checksum generator event pulse
    input  wire [3:0]  src_flag_i,         // flags of timer1, cmp1, cap1, ext0
    output wire [15:0] enable_zero_o,      // enable register zero contents
    output wire [15:0] enable_one_o,       // enable register one contents
    output wire [15:0] enable_two_o,       // enable register two contents
    output wire [15:0] enable_three_o,     // enable register three contents
    output wire [15:0] enable_four_o,      // enable register four contents
    output reg         cpu_req_o,          // request to the core
    output reg  [2:0]  cpu_req_lvl_o,      // level of that request
    output wire        irq_o               // bank interrupt, level
);
`include "iepb_map.vh"

    // ======================================================================
    // register port decode
    wire we_flag = wr_i & (addr_i == `IEPB_OFF_FLAG4);
    wire we_en0  = wr_i & (addr_i == `IEPB_OFF_EN0);
    wire we_en1  = wr_i & (addr_i == `IEPB_OFF_EN1);
    wire we_en2  = wr_i & (addr_i == `IEPB_OFF_EN2);
    wire we_en3  = wr_i & (addr_i == `IEPB_OFF_EN3);
    wire we_en4  = wr_i & (addr_i == `IEPB_OFF_EN4);
    wire we_pri  = wr_i & (addr_i == `IEPB_OFF_PRI0);
    wire we_mask = wr_i & (addr_i == `IEPB_OFF_IRQ_MASK);
    wire rd_stat = rd_i & (addr_i == `IEPB_OFF_IRQ_STAT);

    // ======================================================================
    // flag status four
    wire uart_a_error_flag;
    wire uart_b_error_flag;
    wire checksum_gen_flag;

    iepb_flag_bit u_flag_uart_a (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .set_i     (uart_a_err_evt_i),
        .wr_i      (we_flag),
        .wr_val_i  (wdata_i[`IEPB_FLG_UART_A_ERR]),
        .flag_o    (uart_a_error_flag)                              // RULE1
    );
    iepb_flag_bit u_flag_uart_b (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .set_i     (uart_b_err_evt_i),
        .wr_i      (we_flag),
        .wr_val_i  (wdata_i[`IEPB_FLG_UART_B_ERR]),
        .flag_o    (uart_b_error_flag)
    );
    iepb_flag_bit u_flag_crc (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .set_i     (crc_evt_i),
        .wr_i      (we_flag),
        .wr_val_i  (wdata_i[`IEPB_FLG_CRC]),
        .flag_o    (checksum_gen_flag)
    );

    wire [15:0] flag_four = {12'h000, checksum_gen_flag, uart_b_error_flag,
                             uart_a_error_flag, 1'b0};                 // RULE9

    // ======================================================================
    // enable and priority registers
    reg [15:0] en0_q;
    reg [15:0] en1_q;
    reg [15:0] en2_q;
    reg [15:0] en3_q;
    reg [15:0] en4_q;
    reg [15:0] pri0_q;
    reg [3:0]  mask_q;
    reg [3:0]  stat_q;

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            en0_q  <= `IEPB_RST_EN;
            en1_q  <= `IEPB_RST_EN;
            en2_q  <= `IEPB_RST_EN;
            en3_q  <= `IEPB_RST_EN;
            en4_q  <= `IEPB_RST_EN;
            pri0_q <= `IEPB_RST_PRI0;
            mask_q <= 4'h0;
        end else begin
            // masks drop unimplemented positions at the write
            if (we_en0)
                en0_q <= wdata_i & `IEPB_MASK_EN0;                     // RULE3 RULE9
            if (we_en1)
                en1_q <= wdata_i & `IEPB_MASK_EN1;                     // RULE4
            if (we_en2)
                en2_q <= wdata_i & `IEPB_MASK_EN2;                     // RULE5
            if (we_en3)
                en3_q <= wdata_i & `IEPB_MASK_EN3;
            if (we_en4)
                en4_q <= wdata_i & `IEPB_MASK_EN4;                     // RULE6
            if (we_pri)
                pri0_q <= wdata_i & `IEPB_MASK_PRI0;                   // RULE8
            if (we_mask)
                mask_q <= wdata_i[3:0];
        end
    end

    assign enable_zero_o  = en0_q;
    assign enable_one_o   = en1_q;
    assign enable_two_o   = en2_q;
    assign enable_three_o = en3_q;
    assign enable_four_o  = en4_q;

    // ======================================================================
    // priority-tagged requests for the four prioritised sources
    wire [3:0] src_en = {en0_q[`IEPB_EN0_TIMER_ONE], en0_q[`IEPB_EN0_COMPARE_ONE],
                         en0_q[`IEPB_EN0_CAPTURE_ONE], en0_q[`IEPB_EN0_EXT_ZERO]};
    wire [11:0] src_pri = {pri0_q[`IEPB_PRI_TIMER_ONE +: 3], pri0_q[`IEPB_PRI_COMPARE_ONE +: 3],
                           pri0_q[`IEPB_PRI_CAPTURE_ONE +: 3], pri0_q[`IEPB_PRI_EXT_ZERO +: 3]};
    wire [3:0]  live;
    wire [11:0] lvl;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_src
            iepb_pri_req u_req (
                .flag_i (src_flag_i[gi]),
                .en_i   (src_en[gi]),                                  // RULE2
                .pri_i  (src_pri[gi*3 +: 3]),                          // RULE7
                .req_o  (live[gi]),                                    // RULE10
                .lvl_o  (lvl[gi*3 +: 3])
            );
        end
    endgenerate

    // highest level wins; only the level goes out, so ties need no order
    reg [2:0] best;
    integer   k;
    always @* begin
        best = 3'h0;
        for (k = 0; k < 4; k = k + 1) begin
            if (lvl[k*3 +: 3] > best)
                best = lvl[k*3 +: 3];
        end
    end

    // uart A error goes out at its fixed default level of one
    wire uart_a_live = uart_a_error_flag & en4_q[`IEPB_EN4_UART_A_ERR];   // RULE2 RULE6

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            cpu_req_o     <= 1'b0;
            cpu_req_lvl_o <= 3'h0;
        end else begin
            cpu_req_o     <= (|live) | uart_a_live;                    // RULE10
            cpu_req_lvl_o <= (|live) ? best : (uart_a_live ? 3'h1 : 3'h0);
        end
    end

    // ======================================================================
    // bank interrupt: sticky status, cleared by reading it, set wins
    // own edge history: cpu_req_o also carries the uart A request and would hide a rise
    reg live_any_q;

    always @(posedge ref_clk_i) begin
        if (rst_i)
            live_any_q <= 1'b0;
        else
            live_any_q <= |live;
    end

    wire [3:0] stat_evt;
    assign stat_evt[`IEPB_IST_UART_A_ERR] = uart_a_err_evt_i;
    assign stat_evt[`IEPB_IST_UART_B_ERR] = uart_b_err_evt_i;
    assign stat_evt[`IEPB_IST_CRC]        = crc_evt_i;
    assign stat_evt[`IEPB_IST_PRI_REQ]    = (|live) & ~live_any_q;

    always @(posedge ref_clk_i) begin
        if (rst_i)
            stat_q <= 4'h0;
        else
            stat_q <= (rd_stat ? 4'h0 : stat_q) | stat_evt;
    end

    assign irq_o = |(stat_q & mask_q);

    // ======================================================================
    // read port
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                `IEPB_OFF_FLAG4:    rdata_o <= flag_four;              // RULE1
                `IEPB_OFF_EN0:      rdata_o <= en0_q;
                `IEPB_OFF_EN1:      rdata_o <= en1_q;
                `IEPB_OFF_EN2:      rdata_o <= en2_q;
                `IEPB_OFF_EN3:      rdata_o <= en3_q;
                `IEPB_OFF_EN4:      rdata_o <= en4_q;
                `IEPB_OFF_PRI0:     rdata_o <= pri0_q;
                `IEPB_OFF_IRQ_STAT: rdata_o <= {12'h000, stat_q};
                `IEPB_OFF_IRQ_MASK: rdata_o <= {12'h000, mask_q};
                default:            rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end
endmodule

// ### hdl/iepb_flag_bit.v
// one sticky interrupt flag: hardware set wins over software clear
module iepb_flag_bit (
    input  wire ref_clk_i,   // system clock
    input  wire rst_i,       // synchronous reset, active high
    input  wire set_i,       // hardware event pulse
    input  wire wr_i,        // software write of this bit
    input  wire wr_val_i,    // value written
    output wire flag_o       // current flag
);
    reg flag_q;
    reg flag_d;

    always @* begin
        flag_d = flag_q;
        if (wr_i)
            flag_d = wr_val_i;
        // a same-cycle event must not be lost
        if (set_i)
            flag_d = 1'b1;
    end

    always @(posedge ref_clk_i) begin
        if (rst_i)
            flag_q <= 1'b0;
        else
            flag_q <= flag_d;
    end

    assign flag_o = flag_q;
endmodule

// ### hdl/iepb_map.vh
// register offsets, field positions, reset values and masks of the interrupt bank
`ifndef IEPB_MAP_VH
`define IEPB_MAP_VH

// ==========================================================================
// register offsets (word addresses on the plain register port)
`define IEPB_ADDR_W          4
`define IEPB_OFF_FLAG4       4'h0
`define IEPB_OFF_EN0         4'h1
`define IEPB_OFF_EN1         4'h2
`define IEPB_OFF_EN2         4'h3
`define IEPB_OFF_EN3         4'h4
`define IEPB_OFF_EN4         4'h5
`define IEPB_OFF_PRI0        4'h6
`define IEPB_OFF_IRQ_STAT    4'h7
`define IEPB_OFF_IRQ_MASK    4'h8

// ==========================================================================
// implemented-bit masks: everything else reads zero and ignores writes
`define IEPB_MASK_FLAG4      16'h000E
`define IEPB_MASK_EN0        16'h3FEF
`define IEPB_MASK_EN1        16'hFE1F
`define IEPB_MASK_EN2        16'h22E3
`define IEPB_MASK_EN3        16'h4066
`define IEPB_MASK_EN4        16'h0002
`define IEPB_MASK_PRI0       16'h7777
`define IEPB_MASK_IRQ        16'h000F

// ==========================================================================
// reset values
`define IEPB_RST_FLAG4       16'h0000
`define IEPB_RST_EN          16'h0000
`define IEPB_RST_PRI0        16'h4444
`define IEPB_RST_IRQ         16'h0000

// ==========================================================================
// field positions
`define IEPB_FLG_CRC         3
`define IEPB_FLG_UART_B_ERR  2
`define IEPB_FLG_UART_A_ERR  1
`define IEPB_EN4_UART_A_ERR  1
`define IEPB_EN0_TIMER_ONE   3
`define IEPB_EN0_COMPARE_ONE 2
`define IEPB_EN0_CAPTURE_ONE 1
`define IEPB_EN0_EXT_ZERO    0
`define IEPB_PRI_TIMER_ONE   12
`define IEPB_PRI_COMPARE_ONE 8
`define IEPB_PRI_CAPTURE_ONE 4
`define IEPB_PRI_EXT_ZERO    0
`define IEPB_PRI_W           3

// bank interrupt status bits: one per event class
`define IEPB_IST_UART_A_ERR  0
`define IEPB_IST_UART_B_ERR  1
`define IEPB_IST_CRC         2
`define IEPB_IST_PRI_REQ     3

`endif

// ### hdl/iepb_pri_req.v
// one priority-tagged request: flag, enable and nonzero level all needed
module iepb_pri_req (
    input  wire       flag_i,   // source flag
    input  wire       en_i,     // source enable
    input  wire [2:0] pri_i,    // source priority level
    output wire       req_o,    // request is live
    output wire [2:0] lvl_o     // level of live request, zero otherwise
);
    assign req_o = flag_i & en_i & (pri_i != 3'h0);
    assign lvl_o = req_o ? pri_i : 3'h0;
endmodule

// ### test/iepb_bank_assertions.sv
// concurrent checks on the bank ports
`include "iepb_map.vh"
module iepb_bank_chk (
    input wire logic        ref_clk_i,        // clock
    input wire logic        rst_i,            // reset
    input wire logic [3:0]  addr_i,           // address
    input wire logic [15:0] wdata_i,          // write data
    input wire logic        wr_i,             // write
    input wire logic        rd_i,             // read
    input wire logic [15:0] rdata_o,          // read data
    input wire logic        uart_a_err_evt_i, // event
    input wire logic [3:0]  src_flag_i,       // flags
    input wire logic [15:0] enable_zero_o,    // enables
    input wire logic [15:0] enable_one_o,     // enables
    input wire logic [15:0] enable_four_o,    // enables
    input wire logic        cpu_req_o,        // request
    input wire logic [2:0]  cpu_req_lvl_o     // level
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // ======================================================================
    // register port
    sequence rd_of(logic [3:0] a);
        rd_i && addr_i == a;
    endsequence
    sequence err_then_rd;
        uart_a_err_evt_i ##1 !(wr_i && addr_i == `IEPB_OFF_FLAG4) ##1 rd_of(`IEPB_OFF_FLAG4);
    endsequence
    rdata_idle_a: assert property (!rd_i |=> rdata_o == 16'h0000)
        else $error("read data not zero outside a read");
    unmapped_rd_a: assert property (rd_i && addr_i > 4'h8 |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    en_unimpl_a: assert property ((enable_zero_o & ~`IEPB_MASK_EN0) == 16'h0000
        && (enable_four_o & ~`IEPB_MASK_EN4) == 16'h0000)
        else $error("unimplemented enable bit set");
    en0_write_a: assert property (wr_i && addr_i == `IEPB_OFF_EN0
        |=> enable_zero_o == ($past(wdata_i) & `IEPB_MASK_EN0))
        else $error("enable zero write lost");
    en4_write_a: assert property (wr_i && addr_i == `IEPB_OFF_EN4
        |=> enable_four_o == ($past(wdata_i) & `IEPB_MASK_EN4))
        else $error("enable four write lost");
    en1_read_a: assert property (rd_of(`IEPB_OFF_EN1) |=> rdata_o == $past(enable_one_o))
        else $error("enable one read wrong");
    err_flag_a: assert property (err_then_rd |=> rdata_o[1])
        else $error("uart a error flag not seen");
    // ======================================================================
    // request
    req_level_a: assert property (cpu_req_o == (cpu_req_lvl_o != 3'h0))
        else $error("request and level disagree");
    req_block_a: assert property (src_flag_i == 4'h0 && !enable_four_o[1] |=> !cpu_req_o)
        else $error("request without live source");
endmodule

// ### test/iepb_bank_test.sv
// self-checking bench for the interrupt enable and priority bank
`include "iepb_map.vh"
module iepb_bank_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk_i;
    logic        rst_i;
    logic        wr_i;
    logic        rd_i;
    logic [3:0]  addr_i;
    logic [15:0] wdata_i;
    wire  [15:0] rdata_o;
    wire         cpu_req_o;
    wire         irq_o;
    wire  [2:0]  cpu_req_lvl_o;
    wire  [2:0]  evt;
    wire  [3:0]  src;
    wire  [15:0] en_out [1:5];
    int          failures = 0;
    int          n_tests = 0;
    logic [15:0] msk [0:6];
    iepb_core_model i_src (.ref_clk_i(ref_clk_i), .evt_o(evt), .src_o(src));
    iepb_bank i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .uart_a_err_evt_i(evt[0]), .uart_b_err_evt_i(evt[1]), .crc_evt_i(evt[2]),
        .src_flag_i(src), .enable_zero_o(en_out[1]), .enable_one_o(en_out[2]),
        .enable_two_o(en_out[3]), .enable_three_o(en_out[4]), .enable_four_o(en_out[5]),
        .cpu_req_o(cpu_req_o),
        .cpu_req_lvl_o(cpu_req_lvl_o), .irq_o(irq_o));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask
    // request lags the register it depends on by one edge
    task automatic req(input logic [2:0] l);
        @(posedge ref_clk_i);
        #1 chk({12'h000, cpu_req_o, cpu_req_lvl_o}, {12'h000, l != 3'h0, l});
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        #80us;
        failures++;
        test_done;
    end
    initial begin
        msk = '{`IEPB_MASK_FLAG4, `IEPB_MASK_EN0, `IEPB_MASK_EN1, `IEPB_MASK_EN2,
            `IEPB_MASK_EN3, `IEPB_MASK_EN4, `IEPB_MASK_PRI0};
        rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 16'h0000;
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 10; a++) begin
            rd(a[3:0], a == 6 ? `IEPB_RST_PRI0 : 16'h0000);
        end
        $display("test reset done");
        for (int a = 1; a < 7; a++) begin
            wr(a[3:0], 16'hFFFF);
            rd(a[3:0], msk[a]);
            if (a < 6) chk(en_out[a], msk[a]);
            wr(a[3:0], 16'h0000);
        end
        wr(4'h9, 16'hFFFF);
        rd(4'h9, 16'h0000);
        $display("test layout done");
        i_src.flags(4'h8);
        req(3'h0);
        wr(`IEPB_OFF_EN0, 16'h0008);
        for (int l = 0; l < 8; l++) begin
            wr(`IEPB_OFF_PRI0, {1'b0, 3'(l), 12'h000});
            req(3'(l));
        end
        i_src.flags(4'hF);
        wr(`IEPB_OFF_EN0, 16'h0006);
        wr(`IEPB_OFF_PRI0, 16'h7356);
        req(3'h5);
        i_src.flags(4'h0);
        wr(`IEPB_OFF_EN0, 16'h0000);
        rd(`IEPB_OFF_IRQ_STAT, 16'h0008);
        $display("test request done");
        i_src.pulse(0);
        rd(`IEPB_OFF_FLAG4, 16'h0002);
        chk({15'h0000, irq_o}, 16'h0000);
        req(3'h0);
        wr(`IEPB_OFF_IRQ_MASK, 16'h0001);
        #1 chk({15'h0000, irq_o}, 16'h0001);
        wr(`IEPB_OFF_EN4, 16'h0002);
        req(3'h1);
        rd(`IEPB_OFF_IRQ_STAT, 16'h0001);
        chk({15'h0000, irq_o}, 16'h0000);
        rd(`IEPB_OFF_IRQ_STAT, 16'h0000);
        wr(`IEPB_OFF_FLAG4, 16'h0000);
        rd(`IEPB_OFF_FLAG4, 16'h0000);
        req(3'h0);
        i_src.pulse(1);
        i_src.pulse(2);
        rd(`IEPB_OFF_FLAG4, 16'h000C);
        chk({15'h0000, irq_o}, 16'h0000);
        wr(`IEPB_OFF_IRQ_MASK, 16'h0006);
        #1 chk({15'h0000, irq_o}, 16'h0001);
        rd(`IEPB_OFF_IRQ_STAT, 16'h0006);
        wr(`IEPB_OFF_FLAG4, 16'h0000);
        rd(`IEPB_OFF_FLAG4, 16'h0000);
        $display("test uart error done");
        test_done;
    end
endmodule
bind iepb_bank iepb_bank_chk i_chk (.ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .uart_a_err_evt_i, .src_flag_i, .enable_zero_o, .enable_one_o,
    .enable_four_o, .cpu_req_o, .cpu_req_lvl_o);

// ### test/iepb_core_model.sv
// event source model standing in for the peripherals
module iepb_core_model (
    input  wire logic       ref_clk_i, // clock
    output logic      [2:0] evt_o,     // uart a, uart b, crc pulses
    output logic      [3:0] src_o      // timer1, cmp1, cap1, ext0 flags
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        evt_o = 3'h0;
        src_o = 4'h0;
    end
    // one clean cycle per event so a held level never masks a clear
    task automatic pulse(input int k);
        @(posedge ref_clk_i);
        evt_o <= 3'h1 << k;
        @(posedge ref_clk_i);
        evt_o <= 3'h0;
    endtask
    task automatic flags(input logic [3:0] f);
        @(posedge ref_clk_i);
        src_o <= f;
    endtask
endmodule
